// ---- closed_loop_stop_defs.vh ----
// Offsets, field positions, codes and timing for the stop configuration block
// Contract
// R01 - 32-bit register at 88h, resets to zero, all fields read/write
// R02 - Bits 30-29 pick when speed pulses run: both, closed, first try, reserved
// R03 - Bits 28-25 divide speed pulses; code 0 divides by 3, else by code
// R04 - Bits 23-21 pick back-EMF threshold 1,2,5,10,20,30 mV; 6,7 reserved
// R05 - Bits 20-18 pick stop: high-Z, recirculate, low brake, high brake, spin down
// R06 - Bits 17-14 pick brake time, sixteen steps from 1 ms to 15000 ms
// R07 - Bits 13-11 duty threshold to start braking stops: immediate down to 2.5%
// R08 - Bits 10-8 duty threshold for brake-pin low-side braking, same scale
// R09 - Bit 7 enables the anti-surge deceleration guard
// R10 - Bits 6-3 current limit in 0.1 V steps up to 1.5 V; 0 reserved
// R11 - Parity bit 31 and reserved bits 24, 2-0 just store and read back
`ifndef CLOSED_LOOP_STOP_DEFS_VH
`define CLOSED_LOOP_STOP_DEFS_VH
`define SETTINGS_TWO_ADDR 32'h00000088
`define SETTINGS_TWO_RESET 32'h00000000
`define PARITY_BIT 31
`define MODE_HI 30
`define MODE_LO 29
`define DIV_HI 28
`define DIV_LO 25
`define SPARE_BIT 24
`define BEMF_HI 23
`define BEMF_LO 21
`define STOP_HI 20
`define STOP_LO 18
`define BRK_HI 17
`define BRK_LO 14
`define DUTY_HI 13
`define DUTY_LO 11
`define PIN_HI 10
`define PIN_LO 8
`define SURGE_BIT 7
`define ILIM_HI 6
`define ILIM_LO 3
`define MODE_BOTH 2'h0
`define MODE_CLOSED 2'h1
`define MODE_FIRST 2'h2
`define STOP_HIZ 3'h0
`define STOP_RECIRC 3'h1
`define STOP_LOW 3'h2
`define STOP_HIGH 3'h3
`define STOP_SPIN 3'h4
`define DIV_ZERO_FACTOR 4'h3
`define ILIM_STEP_MV 11'h064
`define CLK_PERIOD_NS 40
`define MS_PERIOD_NS 1000000
`define HSIZE_WORD 3'h2
`endif

// ---- stop_lookup.v ----
// Code-to-value tables for brake time, duty thresholds and back-EMF level
`timescale 1ns/1ps
`include "closed_loop_stop_defs.vh"
module stop_lookup (
  input wire [3:0] brakeCode,
  input wire [2:0] stopDutyCode,
  input wire [2:0] pinDutyCode,
  input wire [2:0] bemfCode,
  output reg [13:0] brakeMs,
  output wire [9:0] stopDutyPermille,
  output wire [9:0] pinDutyPermille,
  output reg [4:0] bemfMv,
  output reg bemfValid
);
  // Immediate is 1000 so any duty passes the compare
  function [9:0] dutyPermille;
    input [2:0] code;
    begin
      case (code)
        3'h0: dutyPermille = 10'h3e8;
        3'h1: dutyPermille = 10'h1f4;
        3'h2: dutyPermille = 10'h0fa;
        3'h3: dutyPermille = 10'h096;
        3'h4: dutyPermille = 10'h064;
        3'h5: dutyPermille = 10'h04b;
        3'h6: dutyPermille = 10'h032;
        default: dutyPermille = 10'h019;
      endcase
    end
  endfunction
  assign stopDutyPermille = dutyPermille(stopDutyCode); // [R07]
  assign pinDutyPermille = dutyPermille(pinDutyCode); // [R08]
  always @* begin
    case (brakeCode) // [R06]
      4'h0: brakeMs = 14'h0001;
      4'h1: brakeMs = 14'h0002;
      4'h2: brakeMs = 14'h0005;
      4'h3: brakeMs = 14'h000a;
      4'h4: brakeMs = 14'h000f;
      4'h5: brakeMs = 14'h0019;
      4'h6: brakeMs = 14'h0032;
      4'h7: brakeMs = 14'h004b;
      4'h8: brakeMs = 14'h0064;
      4'h9: brakeMs = 14'h00fa;
      4'ha: brakeMs = 14'h01f4;
      4'hb: brakeMs = 14'h03e8;
      4'hc: brakeMs = 14'h09c4;
      4'hd: brakeMs = 14'h1388;
      4'he: brakeMs = 14'h2710;
      default: brakeMs = 14'h3a98;
    endcase
  end
  always @* begin
    bemfValid = 1'b1;
    case (bemfCode) // [R04]
      3'h0: bemfMv = 5'h01;
      3'h1: bemfMv = 5'h02;
      3'h2: bemfMv = 5'h05;
      3'h3: bemfMv = 5'h0a;
      3'h4: bemfMv = 5'h14;
      3'h5: bemfMv = 5'h1e;
      default: begin
        bemfMv = 5'h1f;
        bemfValid = 1'b0;
      end
    endcase
  end
endmodule

// ---- speed_pulse_divider.v ----
// Divides electrical half-period edges into the speed-pulse output
`timescale 1ns/1ps
module speed_pulse_divider (
  input wire sys_clk,
  input wire rst_n,
  input wire enable,
  input wire [3:0] factor,
  input wire elecEdge,
  output reg speedPulseOutput
);
  reg [3:0] edgeCount;
  // Toggling every N edges gives electrical rate over N, odd N too
  always @(posedge sys_clk) begin
    if (!rst_n || !enable) begin
      edgeCount <= 4'h0;
      speedPulseOutput <= 1'b0;
    end else if (elecEdge) begin
      if (edgeCount + 4'h1 >= factor) begin // [R03]
        edgeCount <= 4'h0;
        speedPulseOutput <= ~speedPulseOutput;
      end else begin
        edgeCount <= edgeCount + 4'h1;
      end
    end
  end
endmodule

// ---- closed_loop_stop_config_reg.v ----
// Stop and speed-pulse configuration register with its stop sequencer
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "closed_loop_stop_defs.vh"
module closed_loop_stop_config_reg #(
  parameter CYCLES_PER_MS = `MS_PERIOD_NS / `CLK_PERIOD_NS
) (
  input wire sys_clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [2:0] hburst,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire motorRunning,
  input wire closedLoop,
  input wire firstTry,
  input wire elecEdge,
  input wire [7:0] bemfMagnitude,
  input wire [9:0] dutyPermille,
  input wire stopRequest,
  input wire brakePin,
  output wire [1:0] speedPulseModeSelect,
  output wire [3:0] speedPulseDivider,
  output wire [2:0] speedPulseBackemfThreshold,
  output wire [2:0] stopMethodSelect,
  output wire [3:0] stopBrakeDuration,
  output wire [2:0] stopDutyThreshold,
  output wire [2:0] brakePinDutyThreshold,
  output wire surgeGuardEnable,
  output wire [3:0] cycleCurrentLimit,
  output reg [10:0] currentLimitMv,
  output reg currentLimitValid,
  output wire speedPulseOutput,
  output reg bridgeHighZ,
  output reg recirculate,
  output reg lowSideBrake,
  output reg highSideBrake,
  output reg activeSpinDown,
  output reg stopDone
);
  // Stop sequencer states
  localparam ST_RUN = 3'h0;
  localparam ST_RAMP = 3'h1;
  localparam ST_BRAKE = 3'h2;
  localparam ST_COAST = 3'h3;
  localparam ST_DONE = 3'h4;
  localparam [31:0] MS_LAST_FULL = CYCLES_PER_MS - 1;
  localparam [15:0] MS_LAST = MS_LAST_FULL[15:0];

  reg [31:0] settings;
  reg wrHit;
  reg [31:0] next_settings;
  reg brakePinMeta;
  reg brakePinSync;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [2:0] stopMethod;
  reg [15:0] msCount;
  reg [13:0] brakeElapsed;
  reg pinBraking;
  reg next_bridgeHighZ;
  reg next_recirculate;
  reg next_lowSideBrake;
  reg next_highSideBrake;
  reg next_activeSpinDown;
  reg next_stopDone;
  reg modeAllows;
  wire addrPhase;
  reg hitAddr;
  wire msTick;
  wire [3:0] divFactor;
  wire [13:0] brakeMs;
  wire [9:0] stopDutyPermille;
  wire [9:0] pinDutyPermille;
  wire [4:0] bemfMv;
  wire bemfValid;
  wire bemfOk;
  wire stopDutyReached;
  wire pinDutyReached;
  wire brakeOver;
  wire pulseEnable;
  wire stopStart;
  wire [2:0] liveMethod;

  // Zero-wait slave; every answer is OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel & hready & htrans[1];

  // One word is mapped; any other address reads as zero
  always @* begin
    if (haddr == `SETTINGS_TWO_ADDR) begin
      hitAddr = 1'b1;
    end else begin
      hitAddr = 1'b0;
    end
  end

  // A read right behind a write must see the new word
  always @* begin
    next_settings = settings;
    if (wrHit) begin
      next_settings = hwdata; // [R01] [R11]
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      settings <= `SETTINGS_TWO_RESET; // [R01]
      wrHit <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      settings <= next_settings;
      // Narrow writes are dropped rather than merged
      wrHit <= addrPhase & hwrite & hitAddr & (hsize == `HSIZE_WORD);
      if (addrPhase & ~hwrite) begin
        if (hitAddr) begin
          hrdata <= next_settings; // [R01]
        end else begin
          hrdata <= 32'h00000000;
        end
      end
    end
  end

  assign speedPulseModeSelect = settings[`MODE_HI:`MODE_LO]; // [R02]
  assign speedPulseDivider = settings[`DIV_HI:`DIV_LO]; // [R03]
  assign speedPulseBackemfThreshold = settings[`BEMF_HI:`BEMF_LO]; // [R04]
  assign stopMethodSelect = settings[`STOP_HI:`STOP_LO]; // [R05]
  assign stopBrakeDuration = settings[`BRK_HI:`BRK_LO]; // [R06]
  assign stopDutyThreshold = settings[`DUTY_HI:`DUTY_LO]; // [R07]
  assign brakePinDutyThreshold = settings[`PIN_HI:`PIN_LO]; // [R08]
  assign surgeGuardEnable = settings[`SURGE_BIT]; // [R09]
  assign cycleCurrentLimit = settings[`ILIM_HI:`ILIM_LO]; // [R10]

  // Code 0 is reserved, so the limit is flagged not valid
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      currentLimitMv <= 11'h000;
      currentLimitValid <= 1'b0;
    end else begin
      currentLimitMv <= `ILIM_STEP_MV * {7'h00, cycleCurrentLimit}; // [R10]
      currentLimitValid <= (cycleCurrentLimit != 4'h0); // [R10]
    end
  end

  // Tables feed the live compares, so rewrites act at once
  stop_lookup tables (
    .brakeCode(stopBrakeDuration),
    .stopDutyCode(stopDutyThreshold),
    .pinDutyCode(brakePinDutyThreshold),
    .bemfCode(speedPulseBackemfThreshold),
    .brakeMs(brakeMs),
    .stopDutyPermille(stopDutyPermille),
    .pinDutyPermille(pinDutyPermille),
    .bemfMv(bemfMv),
    .bemfValid(bemfValid)
  );

  // Speed pulses: loop-state gating, back-EMF qualification
  always @* begin
    case (speedPulseModeSelect) // [R02]
      `MODE_BOTH: modeAllows = 1'b1;
      `MODE_CLOSED: modeAllows = closedLoop;
      `MODE_FIRST: modeAllows = closedLoop | firstTry;
      default: modeAllows = 1'b0;
    endcase
  end

  assign bemfOk = bemfValid & (bemfMagnitude >= {3'h0, bemfMv}); // [R04]
  // Pulses stop while any stop sequence runs
  assign pulseEnable = motorRunning & modeAllows & bemfOk & (state == ST_RUN);
  assign divFactor = (speedPulseDivider == 4'h0) ? `DIV_ZERO_FACTOR : speedPulseDivider; // [R03]

  speed_pulse_divider divider (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .enable(pulseEnable),
    .factor(divFactor),
    .elecEdge(elecEdge),
    .speedPulseOutput(speedPulseOutput)
  );

  // Brake pin arrives from outside the clock domain
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      brakePinMeta <= 1'b0;
      brakePinSync <= 1'b0;
    end else begin
      brakePinMeta <= brakePin;
      brakePinSync <= brakePinMeta;
    end
  end

  // Immediate maps to 1000, so it passes at any duty
  function dutyAtOrBelow;
    input [9:0] duty;
    input [9:0] limit;
    begin
      dutyAtOrBelow = (duty <= limit);
    end
  endfunction

  assign stopDutyReached = dutyAtOrBelow(dutyPermille, stopDutyPermille); // [R07]
  assign pinDutyReached = dutyAtOrBelow(dutyPermille, pinDutyPermille); // [R08]

  // Millisecond tick restarts on entry to braking for an exact brake time
  assign msTick = (msCount == MS_LAST);
  assign brakeOver = (brakeElapsed >= brakeMs);

  always @(posedge sys_clk) begin
    if (!rst_n || state != ST_BRAKE) begin
      msCount <= 16'h0000;
      brakeElapsed <= 14'h0000;
    end else if (msTick) begin
      msCount <= 16'h0000;
      brakeElapsed <= brakeElapsed + 14'h0001; // [R06]
    end else begin
      msCount <= msCount + 16'h0001;
    end
  end

  // First stop edge must use the method being latched, not the last stop's
  assign stopStart = (state == ST_RUN) & stopRequest;
  assign liveMethod = stopStart ? stopMethodSelect : stopMethod; // [R05]

  // Method latched at stop start; a rewrite mid-stop takes effect next stop
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (stopRequest) begin
          case (stopMethodSelect) // [R05]
            `STOP_LOW: next_state = ST_RAMP;
            `STOP_HIGH: next_state = ST_RAMP;
            `STOP_SPIN: next_state = ST_RAMP;
            default: next_state = ST_COAST;
          endcase
        end
      end
      ST_RAMP: begin
        if (!stopRequest) begin
          next_state = ST_RUN;
        end else if (stopDutyReached) begin
          next_state = ST_BRAKE; // [R07]
        end
      end
      ST_BRAKE: begin
        if (!stopRequest) begin
          next_state = ST_RUN;
        end else if (brakeOver) begin
          next_state = ST_DONE; // [R06]
        end
      end
      // Coasting methods finish one cycle after entry
      ST_COAST: begin
        next_state = stopRequest ? ST_DONE : ST_RUN;
      end
      ST_DONE: begin
        if (!stopRequest) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_RUN;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= ST_RUN;
      stopMethod <= `STOP_HIZ;
      pinBraking <= 1'b0;
    end else begin
      state <= next_state;
      if (stopStart) begin
        stopMethod <= stopMethodSelect; // [R05]
      end
      // Pin braking engages once duty falls low enough and holds while the pin does
      if (!brakePinSync) begin
        pinBraking <= 1'b0;
      end else if (pinDutyReached) begin
        pinBraking <= 1'b1; // [R08]
      end
    end
  end

  // Bridge commands per method and phase; reserved methods coast in high-Z
  always @* begin
    next_bridgeHighZ = 1'b0;
    next_recirculate = 1'b0;
    next_lowSideBrake = 1'b0;
    next_highSideBrake = 1'b0;
    next_activeSpinDown = 1'b0;
    next_stopDone = 1'b0;
    case (next_state)
      ST_RAMP: begin
        next_activeSpinDown = (liveMethod == `STOP_SPIN); // [R05]
      end
      ST_BRAKE: begin
        next_highSideBrake = (liveMethod == `STOP_HIGH); // [R05]
        next_lowSideBrake = (liveMethod != `STOP_HIGH); // [R05]
      end
      ST_COAST, ST_DONE: begin
        next_recirculate = (liveMethod == `STOP_RECIRC); // [R05]
        next_bridgeHighZ = (liveMethod != `STOP_RECIRC); // [R05]
        next_stopDone = (next_state == ST_DONE);
      end
      default: begin
        next_lowSideBrake = pinBraking; // [R08]
      end
    endcase
    // Brake-pin braking yields to a commanded stop
    if (stopStart) begin
      next_lowSideBrake = 1'b0;
    end
  end

  // Registered so the bridge never sees a decode glitch
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      bridgeHighZ <= 1'b0;
      recirculate <= 1'b0;
      lowSideBrake <= 1'b0;
      highSideBrake <= 1'b0;
      activeSpinDown <= 1'b0;
      stopDone <= 1'b0;
    end else begin
      bridgeHighZ <= next_bridgeHighZ;
      recirculate <= next_recirculate;
      lowSideBrake <= next_lowSideBrake;
      highSideBrake <= next_highSideBrake;
      activeSpinDown <= next_activeSpinDown;
      stopDone <= next_stopDone;
    end
  end

endmodule

// ---- closed_loop_stop_checker.sv ----
// Concurrent checks on the ports of the stop configuration block
`timescale 1ns/1ps
module closed_loop_stop_checker (
  input wire sys_clk,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire motorRunning,
  input wire stopRequest,
  input wire [1:0] speedPulseModeSelect,
  input wire [3:0] speedPulseDivider,
  input wire [2:0] speedPulseBackemfThreshold,
  input wire [2:0] stopMethodSelect,
  input wire [3:0] stopBrakeDuration,
  input wire [2:0] stopDutyThreshold,
  input wire [2:0] brakePinDutyThreshold,
  input wire surgeGuardEnable,
  input wire [3:0] cycleCurrentLimit,
  input wire [10:0] currentLimitMv,
  input wire currentLimitValid,
  input wire speedPulseOutput,
  input wire bridgeHighZ,
  input wire recirculate,
  input wire highSideBrake,
  input wire activeSpinDown,
  input wire stopDone
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire taken = hsel && hready && htrans[1];
  wire mapped = haddr == 32'h00000088;
  wire wrOk = taken && hwrite && mapped && hsize == 3'h2;
  // Parity and spare bits have no port, so they are masked out of the view
  wire [31:0] view = {1'b0, speedPulseModeSelect, speedPulseDivider, 1'b0,
    speedPulseBackemfThreshold, stopMethodSelect, stopBrakeDuration, stopDutyThreshold,
    brakePinDutyThreshold, surgeGuardEnable, cycleCurrentLimit, 3'h0};
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  wr_mode_a: assert property (wrOk |-> ##2 view[30:25] == $past(hwdata[30:25]))
    else $error("mode or divider not stored");
  wr_stop_a: assert property (wrOk |-> ##2 view[23:18] == $past(hwdata[23:18]))
    else $error("threshold or stop method not stored");
  wr_brake_a: assert property (wrOk |-> ##2 view[17:11] == $past(hwdata[17:11]))
    else $error("brake time or duty not stored");
  wr_limit_a: assert property (wrOk |-> ##2 view[10:3] == $past(hwdata[10:3]))
    else $error("pin duty, guard or limit not stored");
  rd_view_a: assert property (taken && !hwrite && mapped |=> (hrdata & 32'h7efffff8) == view)
    else $error("read data differs from fields");
  rd_unmapped_a: assert property (taken && !hwrite && !mapped |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  ilim_value_a: assert property (currentLimitMv == $past(cycleCurrentLimit) * 11'h064
    && currentLimitValid == ($past(cycleCurrentLimit) != 4'h0))
    else $error("current limit value wrong");
  pulse_off_a: assert property (!motorRunning |=> !speedPulseOutput)
    else $error("speed pulse while stopped");
  hiz_stop_a: assert property (
    stopRequest && !$past(stopRequest) && stopMethodSelect == 3'h0
    |=> bridgeHighZ && !stopDone ##1 stopDone)
    else $error("high impedance stop wrong");
  stop_clear_a: assert property (!stopRequest
    |=> !(bridgeHighZ || recirculate || highSideBrake || activeSpinDown || stopDone))
    else $error("stop outputs not cleared");
endmodule
bind closed_loop_stop_config_reg closed_loop_stop_checker chk_u (.sys_clk, .rst_n, .hsel,
  .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp,
  .motorRunning, .stopRequest, .speedPulseModeSelect, .speedPulseDivider,
  .speedPulseBackemfThreshold, .stopMethodSelect, .stopBrakeDuration, .stopDutyThreshold,
  .brakePinDutyThreshold, .surgeGuardEnable, .cycleCurrentLimit, .currentLimitMv,
  .currentLimitValid, .speedPulseOutput, .bridgeHighZ, .recirculate, .highSideBrake,
  .activeSpinDown, .stopDone);

// ---- tb_closed_loop_stop_config_reg.sv ----
// Self-checking bench for the stop configuration block
`timescale 1ns/1ps
`include "closed_loop_stop_defs.vh"
module tb_closed_loop_stop_config_reg;
  localparam M = 10;
  reg sys_clk = 0;
  reg rst_n = 0;
  reg hsel = 0;
  reg [31:0] haddr = 0;
  reg [1:0] htrans = 0;
  reg hwrite = 0;
  reg [2:0] hsize = 0;
  reg [31:0] hwdata = 0;
  reg motorRunning = 0, closedLoop = 0, firstTry = 0, elecEdge = 0, stopRequest = 0;
  reg brakePin = 0;
  reg [7:0] bemfMagnitude = 0;
  reg [9:0] dutyPermille = 0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, surgeGuardEnable, currentLimitValid, speedPulseOutput;
  wire [1:0] speedPulseModeSelect;
  wire [3:0] speedPulseDivider, stopBrakeDuration, cycleCurrentLimit;
  wire [2:0] speedPulseBackemfThreshold, stopMethodSelect, stopDutyThreshold;
  wire [2:0] brakePinDutyThreshold;
  wire [10:0] currentLimitMv;
  wire bridgeHighZ, recirculate, lowSideBrake, highSideBrake, activeSpinDown, stopDone;
  integer bad_count = 0, n_tests = 0, i, j, k, n;
  reg [31:0] model = 0, lfsr = 3, got;
  closed_loop_stop_config_reg #(.CYCLES_PER_MS(M)) dut_u (.sys_clk, .rst_n, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hburst(3'h0), .hready(hreadyout), .hwdata, .hrdata,
    .hreadyout, .hresp, .motorRunning, .closedLoop, .firstTry, .elecEdge, .bemfMagnitude,
    .dutyPermille, .stopRequest, .brakePin, .speedPulseModeSelect, .speedPulseDivider,
    .speedPulseBackemfThreshold, .stopMethodSelect, .stopBrakeDuration, .stopDutyThreshold,
    .brakePinDutyThreshold, .surgeGuardEnable, .cycleCurrentLimit, .currentLimitMv,
    .currentLimitValid, .speedPulseOutput, .bridgeHighZ, .recirculate, .lowSideBrake,
    .highSideBrake, .activeSpinDown, .stopDone);
  function [31:0] rnd(input [31:0] s);
    rnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task final_report;
    begin
      if (bad_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] s);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask
  // No fixed latency is assumed; only the watchdog ends a stuck wait
  task ack;
    begin
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
    end
  endtask
  task xfer(input w, input [31:0] a, input [31:0] d, input [2:0] sz);
    begin
      @(posedge sys_clk);
      hsel <= 1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= sz;
      ack;
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      ack;
      got = hrdata;
      if (w && a == `SETTINGS_TWO_ADDR && sz == `HSIZE_WORD) model = d;
    end
  endtask
  task fchk;
    begin
      chk("mode", model[30:29], speedPulseModeSelect);
      chk("div", model[28:25], speedPulseDivider);
      chk("bemf", model[23:21], speedPulseBackemfThreshold);
      chk("stop", model[20:18], stopMethodSelect);
      chk("brk", model[17:14], stopBrakeDuration);
      chk("duty", model[13:11], stopDutyThreshold);
      chk("pin", model[10:8], brakePinDutyThreshold);
      chk("surge", model[7], surgeGuardEnable);
      chk("ilim", model[6:3], cycleCurrentLimit);
    end
  endtask
  task sp(input [1:0] m, input [3:0] d, input [2:0] b, input [7:0] mag, input cl,
      input ft, input [31:0] e);
    begin
      xfer(1, `SETTINGS_TWO_ADDR, {1'b0, m, d, 1'b0, b, 21'h0}, `HSIZE_WORD);
      motorRunning <= 0;
      bemfMagnitude <= mag;
      closedLoop <= cl;
      firstTry <= ft;
      @(posedge sys_clk);
      motorRunning <= 1;
      n = 0;
      for (j = 1; j <= 20 && n == 0; j = j + 1) begin
        @(posedge sys_clk);
        elecEdge <= 1;
        @(posedge sys_clk);
        elecEdge <= 0;
        @(posedge sys_clk);
        if (speedPulseOutput !== 1'b0) n = j;
      end
      chk("edges", e, n);
    end
  endtask
  task st(input [2:0] m, input [3:0] b, input [31:0] e);
    begin
      xfer(1, `SETTINGS_TWO_ADDR, {11'h0, m, b, 14'h0}, `HSIZE_WORD);
      stopRequest <= 1;
      repeat (2) @(posedge sys_clk);
      if (m < 2 || m > 4) begin
        chk("hiz", m != 1, bridgeHighZ);
        chk("recirc", m == 1, recirculate);
        chk("early", 0, stopDone);
        @(posedge sys_clk);
      end else begin
        chk("spin", m == 4, activeSpinDown);
        n = 0;
        @(posedge sys_clk);
        while ((m == 3 ? highSideBrake : lowSideBrake) === 1'b1 && n < 400) begin
          n = n + 1;
          @(posedge sys_clk);
        end
        chk("brake", e, n);
        chk("hiz", 1, bridgeHighZ);
      end
      chk("done", 1, stopDone);
      stopRequest <= 0;
      repeat (2) @(posedge sys_clk);
      chk("clear", 0, {bridgeHighZ, recirculate, lowSideBrake, highSideBrake, stopDone});
    end
  endtask
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #(40 * 40000);
    bad_count = bad_count + 1;
    final_report;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1;
    xfer(0, `SETTINGS_TWO_ADDR, 0, `HSIZE_WORD);
    chk("reset", 0, got);
    for (i = 0; i < 16; i = i + 1) begin
      lfsr = rnd(lfsr);
      xfer(1, `SETTINGS_TWO_ADDR, (lfsr & 32'hffffff87) | (i << 3), `HSIZE_WORD);
      repeat (2) @(posedge sys_clk);
      fchk;
      chk("mv", i * 100, currentLimitMv);
      chk("valid", i != 0, currentLimitValid);
      xfer(0, `SETTINGS_TWO_ADDR, 0, `HSIZE_WORD);
      chk("read", model, got);
    end
    xfer(1, `SETTINGS_TWO_ADDR, ~model, 3'h1);
    xfer(1, 32'h0000008c, ~model, `HSIZE_WORD);
    xfer(0, 32'h0000008c, 0, `HSIZE_WORD);
    chk("unmap", 0, got);
    xfer(0, `SETTINGS_TWO_ADDR, 0, `HSIZE_WORD);
    chk("kept", model, got);
    sp(0, 0, 0, 8'hff, 0, 0, 3);
    sp(0, 1, 0, 8'hff, 0, 0, 1);
    sp(0, 4'hf, 0, 8'hff, 0, 0, 15);
    sp(1, 2, 0, 8'hff, 0, 0, 0);
    sp(1, 2, 0, 8'hff, 1, 0, 2);
    sp(2, 2, 0, 8'hff, 0, 1, 2);
    sp(2, 2, 0, 8'hff, 0, 0, 0);
    sp(3, 2, 0, 8'hff, 1, 1, 0);
    sp(0, 2, 5, 8'h1d, 0, 0, 0);
    sp(0, 2, 5, 8'h1e, 0, 0, 2);
    sp(0, 2, 6, 8'hff, 0, 0, 0);
    sp(0, 2, 0, 8'h00, 0, 0, 0);
    motorRunning <= 0;
    for (i = 0; i < 8; i = i + 1) st(i, i == 4 ? 0 : 1, i == 4 ? M + 1 : 2 * M + 1);
    xfer(1, `SETTINGS_TWO_ADDR, {11'h0, 3'h2, 4'h0, 3'h1, 11'h0}, `HSIZE_WORD);
    dutyPermille <= 600;
    stopRequest <= 1;
    repeat (6) @(posedge sys_clk);
    chk("ramp", 0, lowSideBrake);
    dutyPermille <= 500;
    repeat (3) @(posedge sys_clk);
    chk("thr", 1, lowSideBrake);
    stopRequest <= 0;
    xfer(1, `SETTINGS_TWO_ADDR, {21'h0, 3'h2, 8'h0}, `HSIZE_WORD);
    dutyPermille <= 300;
    brakePin <= 1;
    repeat (8) @(posedge sys_clk);
    chk("pinhold", 0, lowSideBrake);
    dutyPermille <= 250;
    repeat (8) @(posedge sys_clk);
    chk("pinbrk", 1, lowSideBrake);
    brakePin <= 0;
    repeat (8) @(posedge sys_clk);
    chk("pinoff", 0, lowSideBrake);
    rst_n <= 0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1;
    model = 0;
    xfer(0, `SETTINGS_TWO_ADDR, 0, `HSIZE_WORD);
    chk("rereset", 0, got);
    fchk;
    final_report;
  end
endmodule
